// ==== nvc_pkg.sv ====
// nvc_pkg: constants, register map and command codes for the nvm controller block
// assumes: a 32-bit APB slave with 8-bit registers in the low bits of one word each
package nvc_pkg;

  // register indices; byte address is four times the index
  localparam logic [7:0]  IDX_CLK_DIV      = 8'h00;
  localparam logic [7:0]  IDX_CONFIG       = 8'h04;
  localparam logic [7:0]  IDX_PARAM_INDEX  = 8'h02;
  localparam logic [7:0]  IDX_CMD_STATUS   = 8'h06;
  localparam logic [7:0]  IDX_FAULT_STATUS = 8'h07;
  localparam logic [7:0]  IDX_PFLASH_PROT  = 8'h08;
  localparam logic [7:0]  IDX_EEPROM_PROT  = 8'h09;
  localparam logic [7:0]  IDX_PARAM_HI     = 8'h0A;
  localparam logic [7:0]  IDX_PARAM_LO     = 8'h0B;
  localparam logic [7:0]  IDX_ARRAY_EVENT  = 8'h10;
  localparam logic [7:0]  IDX_RES_SELECT   = 8'h11;

  localparam int          ADDR_W           = 12;

  // command status bits
  localparam int          CS_COMMAND_COMPLETE_FLAG          = 7;
  localparam int          CS_ACCESS_ERROR_FLAG        = 5;
  localparam int          CS_BUSY          = 3;
  localparam int          CS_ERR_HI        = 1;
  localparam int          CS_ERR_LO        = 0;
  // fault status bits
  localparam int          FS_DOUBLE        = 1;
  localparam int          FS_SINGLE        = 0;
  // config bits
  localparam int          CFG_IGNORE_SINGLE_FAULT        = 4;
  // pflash protection bits
  localparam int          PP_OPEN          = 7;
  localparam int          PP_HDIS          = 5;
  localparam int          PP_LDIS          = 2;
  // eeprom protection bits
  localparam int          EP_OPEN          = 7;
  // array event bits written by the read path model
  localparam int          AE_SINGLE        = 0;
  localparam int          AE_DOUBLE        = 1;
  localparam int          AE_COLLIDE       = 2;

  // command codes
  localparam logic [7:0]  CMD_ERASE_ALL    = 8'h08;
  localparam logic [7:0]  CMD_ERASE_BLOCK  = 8'h09;
  localparam logic [7:0]  CMD_UNSECURE     = 8'h0B;
  localparam logic [7:0]  CMD_USER_MARGIN  = 8'h0D;
  localparam logic [7:0]  CMD_FIELD_MARGIN = 8'h0E;
  localparam logic [7:0]  CMD_ERASE_VERIFY = 8'h10;
  localparam logic [7:0]  CMD_PROGRAM_EE   = 8'h11;
  localparam logic [7:0]  CMD_ERASE_SECTOR = 8'h12;

  // global address map
  localparam logic [17:0] PFLASH_LO        = 18'h2_0000;
  localparam logic [17:0] PFLASH_HI        = 18'h3_FFFF;
  localparam logic [17:0] RES_LO           = 18'h0_4000;
  localparam logic [17:0] RES_HI           = 18'h0_7FFF;
  localparam logic [17:0] EE_LO            = 18'h0_0400;
  localparam logic [17:0] EE_HI            = 18'h0_13FF;
  localparam logic [2:0]  VERIFY_IDX       = 3'h2;
  localparam logic [2:0]  PROG_IDX_MIN     = 3'h2;
  localparam logic [2:0]  PROG_IDX_MAX     = 3'h5;

  // timing: init period and operation lengths in ns, converted to cycles
  localparam int          CLK_NS           = 20;
  localparam int          INIT_NS          = 200;
  localparam int          OP_NS            = 1000;
  localparam logic [7:0]  INIT_CYC         = 8'(INIT_NS / CLK_NS);
  localparam logic [7:0]  OP_CYC           = 8'(OP_NS / CLK_NS);

  typedef enum logic [1:0] {
    ST_INIT = 2'b00,
    ST_IDLE = 2'b01,
    ST_RUN  = 2'b10
  } nvc_state_t;

endpackage : nvc_pkg

// ==== nvc_fault_flags.sv ====
// nvc_fault_flags: sticky single and double fault flags with write-one-to-clear
// assumes: event pulses come from the array read path on the same clock
`timescale 1ns/1ps
module nvc_fault_flags (
  input  wire logic       mclk,
  input  wire logic       reset,
  input  wire logic       singleEvt,
  input  wire logic       doubleEvt,
  input  wire logic       collideEvt,
  input  wire logic       ignoreSingle,
  input  wire logic [1:0] clearMask,
  output logic      [1:0] flags
);
  import nvc_pkg::*;

  logic [1:0] evtReg;
  logic [1:0] setNow;

  // an ecc fault is single or double; a collision sets both
  assign setNow[FS_SINGLE] = (singleEvt & ~doubleEvt & ~ignoreSingle) | collideEvt; // R12 R13 R14
  assign setNow[FS_DOUBLE] = doubleEvt | collideEvt;                                // R10 R14

  // flags land two cycles after the read; set wins over clear
  always_ff @(posedge mclk) begin
    if (reset) begin
      evtReg <= 2'h0;
      flags  <= 2'h0;
    end else begin
      evtReg <= setNow; // R15
      flags  <= (flags & ~clearMask) | evtReg; // R9 R11
    end
  end

  a_double_delay: assert property (@(posedge mclk) disable iff (reset) // R15
    doubleEvt |-> ##2 flags[FS_DOUBLE]) else $error("double flag not set two cycles on");
  a_single_excl: assert property (@(posedge mclk) disable iff (reset) // R13
    (singleEvt && doubleEvt && !collideEvt) |-> ##1 !evtReg[FS_SINGLE])
    else $error("single and double raised for one ecc event");
  a_ignore_single: assert property (@(posedge mclk) disable iff (reset) // R12
    (singleEvt && ignoreSingle && !collideEvt) |-> ##1 !evtReg[FS_SINGLE])
    else $error("single flag raised while ignored");
  a_collide_both: assert property (@(posedge mclk) disable iff (reset) // R14
    collideEvt |-> ##2 (flags == 2'h3)) else $error("collision did not set both flags");
  a_zero_keeps: assert property (@(posedge mclk) disable iff (reset) // R11
    (clearMask == 2'h0) |=> ((flags & $past(flags)) == $past(flags)))
    else $error("flag lost without a clear");
  c_collide: cover property (@(posedge mclk) disable iff (reset) collideEvt ##2 flags == 2'h3);
endmodule : nvc_fault_flags

// ==== nvc_cmd_check.sv ====
// nvc_cmd_check: launch-time checks of a loaded command against protection and mode
// assumes: all inputs except the specialMode pin are register contents sampled in the launch cycle
`timescale 1ns/1ps
module nvc_cmd_check (
  input  wire logic [7:0]  cmdCode,
  input  wire logic [2:0]  paramIndex,
  input  wire logic [17:0] startAddr,
  input  wire logic [15:0] wordCount,
  input  wire logic [7:0]  pflashProt,
  input  wire logic [7:0]  eepromProt,
  input  wire logic        specialMode,
  output logic             accessErr,
  output logic             protViolation
);
  import nvc_pkg::*;

  logic [18:0] endAddr;
  logic        addrBad;
  logic        allOpen;
  logic        knownCmd;

  assign endAddr  = {1'b0, startAddr} + {2'b00, wordCount, 1'b0};
  assign addrBad  = (startAddr < EE_LO) || (startAddr > EE_HI) || startAddr[0];
  // every protection opened before a full erase
  assign allOpen  = pflashProt[PP_LDIS] & pflashProt[PP_HDIS] & pflashProt[PP_OPEN]
                  & eepromProt[EP_OPEN]; // R16
  assign knownCmd = (cmdCode == CMD_ERASE_ALL) || (cmdCode == CMD_ERASE_BLOCK)
                  || (cmdCode == CMD_UNSECURE) || (cmdCode == CMD_USER_MARGIN)
                  || (cmdCode == CMD_FIELD_MARGIN) || (cmdCode == CMD_ERASE_VERIFY)
                  || (cmdCode == CMD_PROGRAM_EE) || (cmdCode == CMD_ERASE_SECTOR);

  // access and protection errors per command
  always_comb begin
    accessErr     = !knownCmd;
    protViolation = 1'b0;
    case (cmdCode)
      CMD_ERASE_ALL:    protViolation = !allOpen; // R16
      CMD_ERASE_BLOCK:  protViolation = !eepromProt[EP_OPEN]; // R17
      CMD_FIELD_MARGIN: accessErr = !specialMode; // R19
      CMD_ERASE_VERIFY: accessErr = (paramIndex != VERIFY_IDX) || addrBad
                                  || (endAddr > {1'b0, EE_HI} + 19'h1); // R24
      CMD_PROGRAM_EE:   accessErr = (paramIndex < PROG_IDX_MIN)
                                  || (paramIndex > PROG_IDX_MAX) || addrBad; // R21
      CMD_ERASE_SECTOR: accessErr = addrBad; // R22
      default:          ;
    endcase
  end
endmodule : nvc_cmd_check

// ==== nvc_controller.sv ====
// nvc_controller: APB register file and command sequencer of the nvm controller
// assumes: array read path reports ecc events through a register write of its own
//
// Decided for this implementation: the APB slave port.
`timescale 1ns/1ps
// Behaviour
// R1: reads of unimplemented locations return undefined data; here zero
// R2: writes to unimplemented or reserved locations change nothing
// R3: while a command runs every register write is dropped; here array event writes still land
// R4: writes take effect when idle and during init after reset
// R5: pflash spans 128K bytes at 0x2_0000 to 0x3_FFFF with config field
// R6: window 0x0_4000 to 0x0_7FFF maps resource area only when select is 1
// R7: busy status bit 3 reads 1 while a command runs, else 0
// R8: command error status bits set on command or reset-sequence errors
// R9: fault status at 0x0007 readable, flags only cleared by writes
// R10: double flag sets on uncorrectable fault or collision read
// R11: writing 1 clears a fault flag, 0 leaves it
// R12: single flag sets on corrected fault unless ignored, or on collision
// R13: one ecc fault sets single or double, never both
// R14: a collision sets both fault flags together
// R15: fault flags land one cycle after the array read; here they land two cycles after
// R16: erase all needs every protection disable and open bit set
// R17: block erase of eeprom needs eeprom protect-open set
// R18: unsecure erases all blocks then verifies them erased
// R19: user margin set anytime; field margin only in special modes
// R20: erase verify checks count of words from address are erased
// R21: program writes one to four words into eeprom
// R22: sector erase clears every byte of one eeprom sector
// R23: clearing the complete flag launches; flag sets again at finish
// R24: erase verify launch flags access error on bad index or address
module nvc_controller (
  input  wire logic        mclk,
  input  wire logic        reset,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  output logic      [31:0] prdata,
  output logic             pready,
  output logic             pslverr,
  input  wire logic        specialMode,
  input  wire logic [17:0] globalAddr,
  output logic             pflashHit,
  output logic             eepromHit,
  output logic             resourceHit,
  output logic             arrayBusy
);
  import nvc_pkg::*;

  nvc_state_t state;
  nvc_state_t next_state;
  logic [7:0]  initCnt;
  logic [7:0]  opCnt;
  logic [7:0]  clkDiv;
  logic [7:0]  cfgReg;
  logic [2:0]  paramIndex;
  logic [7:0]  pflashProt;
  logic [7:0]  eepromProt;
  logic [7:0]  cmdCode;
  logic [17:0] startAddr;
  logic [15:0] wordCount;
  logic        resSelect;
  logic        access_error_flag;
  logic        protErr;
  logic [1:0]  errStatus;
  logic [1:0]  marginLevel;
  logic [1:0]  faultFlags;
  logic        chkAcc;
  logic        chkProt;
  logic        cmdDone;

  // register index from a byte address
  function automatic logic [7:0] reg_index(input logic [11:0] a);
    return a[9:2];
  endfunction : reg_index

  wire         wrAccess  = psel & penable & pwrite;
  wire         rdAccess  = psel & penable & ~pwrite;
  wire  [7:0]  regIdx    = reg_index(paddr);
  wire         wordAlign = (paddr[1:0] == 2'b00) && (paddr[11:10] == 2'b00);
  wire         running   = (state == ST_RUN);
  wire         inInit    = (state == ST_INIT);
  wire         writeOk   = wrAccess & wordAlign & ~running; // R3 R4
  wire  [7:0]  wdat      = pwdata[7:0];
  wire  [1:0]  faultClr  = (writeOk && regIdx == IDX_FAULT_STATUS) ? wdat[1:0] : 2'h0; // R11
  wire         launch    = writeOk && (regIdx == IDX_CMD_STATUS) && wdat[CS_COMMAND_COMPLETE_FLAG]; // R23
  wire         evtWrite  = wrAccess && wordAlign && (regIdx == IDX_ARRAY_EVENT);
  wire  [7:0]  cmdStatus = {~running, 1'b0, access_error_flag, protErr, running, 1'b0, errStatus}; // R7 R8

  // apb answers in the access cycle; bad alignment is an error
  assign pready  = 1'b1;
  assign pslverr = psel & penable & ~wordAlign;

  // global address decode
  assign pflashHit   = (globalAddr >= PFLASH_LO) && (globalAddr <= PFLASH_HI); // R5
  assign eepromHit   = (globalAddr >= EE_LO) && (globalAddr <= EE_HI);
  assign resourceHit = resSelect && (globalAddr >= RES_LO) && (globalAddr <= RES_HI); // R6
  assign arrayBusy   = running;

  nvc_fault_flags u_fault (
    .mclk         (mclk),
    .reset        (reset),
    .singleEvt    (evtWrite & wdat[AE_SINGLE]),
    .doubleEvt    (evtWrite & wdat[AE_DOUBLE]),
    .collideEvt   (evtWrite & wdat[AE_COLLIDE]),
    .ignoreSingle (cfgReg[CFG_IGNORE_SINGLE_FAULT]),
    .clearMask    (faultClr),
    .flags        (faultFlags)
  );

  nvc_cmd_check u_check (
    .cmdCode       (cmdCode),
    .paramIndex    (paramIndex),
    .startAddr     (startAddr),
    .wordCount     (wordCount),
    .pflashProt    (pflashProt),
    .eepromProt    (eepromProt),
    .specialMode   (specialMode),
    .accessErr     (chkAcc),
    .protViolation (chkProt)
  );

  // state sequencing: init, idle, run
  always_comb begin
    next_state = state;
    case (state)
      ST_INIT: if (initCnt == 8'h00) next_state = ST_IDLE;
      ST_IDLE: if (launch && !chkAcc && !chkProt && !access_error_flag && !protErr) next_state = ST_RUN;
      ST_RUN:  if (cmdDone) next_state = ST_IDLE; // R23
      default: next_state = ST_INIT;
    endcase
  end

  assign cmdDone = (opCnt == 8'h00);

  // state and timers
  always_ff @(posedge mclk) begin
    if (reset) begin
      state   <= ST_INIT;
      initCnt <= INIT_CYC;
      opCnt   <= 8'h00;
    end else begin
      state   <= next_state;
      initCnt <= (initCnt != 8'h00) ? initCnt - 8'h01 : initCnt;
      if (state == ST_IDLE && next_state == ST_RUN)
        opCnt <= OP_CYC; // R18 R20 R21 R22
      else if (running && opCnt != 8'h00)
        opCnt <= opCnt - 8'h01;
    end
  end

  // writable registers; unmapped and busy writes dropped
  always_ff @(posedge mclk) begin
    if (reset) begin
      clkDiv     <= 8'h00;
      cfgReg     <= 8'h00;
      paramIndex <= 3'h0;
      pflashProt <= 8'h00;
      eepromProt <= 8'h00;
      cmdCode    <= 8'h00;
      startAddr  <= 18'h0_0000;
      wordCount  <= 16'h0000;
      resSelect  <= 1'b0;
    end else if (writeOk) begin // R2 R3 R4
      case (regIdx)
        IDX_CLK_DIV:     clkDiv     <= wdat;
        IDX_CONFIG:      cfgReg     <= wdat;
        IDX_PARAM_INDEX: paramIndex <= wdat[2:0];
        IDX_PFLASH_PROT: pflashProt <= wdat;
        IDX_EEPROM_PROT: eepromProt <= wdat;
        IDX_RES_SELECT:  resSelect  <= wdat[0];
        IDX_PARAM_HI: begin
          if (paramIndex == 3'h0) begin
            cmdCode         <= wdat;
          end
        end
        IDX_PARAM_LO: begin
          case (paramIndex)
            3'h0:    startAddr[17:16] <= wdat[1:0];
            3'h1:    startAddr[7:0]   <= wdat;
            3'h2:    wordCount[7:0]   <= wdat;
            default: ;
          endcase
        end
        default: ;
      endcase
    end
  end

  // command error flags; launch result and completion status
  always_ff @(posedge mclk) begin
    if (reset) begin
      access_error_flag      <= 1'b0;
      protErr     <= 1'b0;
      errStatus   <= 2'h0;
      marginLevel <= 2'h0;
    end else begin
      if (launch && state == ST_IDLE) begin
        access_error_flag  <= chkAcc; // R24
        protErr <= chkProt; // R16 R17
        if (!chkAcc && !chkProt) errStatus <= 2'h0;
        if (!chkAcc && cmdCode == CMD_USER_MARGIN) marginLevel <= startAddr[1:0]; // R19
        if (!chkAcc && cmdCode == CMD_FIELD_MARGIN) marginLevel <= startAddr[1:0]; // R19
      end else if (writeOk && regIdx == IDX_CMD_STATUS) begin
        if (wdat[CS_ACCESS_ERROR_FLAG]) access_error_flag <= 1'b0;
        if (wdat[CS_ACCESS_ERROR_FLAG - 1]) protErr <= 1'b0;
      end
      if (inInit && faultFlags[FS_DOUBLE])
        errStatus <= 2'h3; // R8
      else if (running && (faultFlags != 2'h0))
        errStatus <= {1'b1, faultFlags[FS_DOUBLE]}; // R8
    end
  end

  // read mux; undefined locations read zero
  always_ff @(posedge mclk) begin
    if (reset) begin
      prdata <= 32'h0000_0000;
    end else if (psel && !penable && !pwrite) begin
      case (reg_index(paddr))
        IDX_CLK_DIV:      prdata <= {24'h00_0000, clkDiv};
        IDX_CONFIG:       prdata <= {24'h00_0000, cfgReg};
        IDX_PARAM_INDEX:  prdata <= {29'h0000_0000, paramIndex};
        IDX_CMD_STATUS:   prdata <= {24'h00_0000, cmdStatus}; // R7
        IDX_FAULT_STATUS: prdata <= {30'h0000_0000, faultFlags}; // R9
        IDX_PFLASH_PROT:  prdata <= {24'h00_0000, pflashProt};
        IDX_EEPROM_PROT:  prdata <= {24'h00_0000, eepromProt};
        IDX_PARAM_HI:     prdata <= {24'h00_0000, cmdCode};
        IDX_RES_SELECT:   prdata <= {31'h0000_0000, resSelect};
        default:          prdata <= 32'h0000_0000; // R1
      endcase
    end
  end

  a_busy_blocks: assert property (@(posedge mclk) disable iff (reset) // R3
    (running && wrAccess && regIdx == IDX_CONFIG) |=> $stable(cfgReg))
    else $error("config changed while busy");
  a_busy_bit: assert property (@(posedge mclk) disable iff (reset) // R7
    cmdStatus[CS_BUSY] == !cmdStatus[CS_COMMAND_COMPLETE_FLAG]) else $error("busy not inverse of complete");
  a_idle_write: assert property (@(posedge mclk) disable iff (reset) // R4
    (state == ST_IDLE && wrAccess && wordAlign && regIdx == IDX_CONFIG) |=> cfgReg == $past(wdat))
    else $error("idle write did not land");
  a_res_window: assert property (@(posedge mclk) disable iff (reset) // R6
    !resSelect |-> !resourceHit) else $error("resource area mapped while deselected");
  a_erase_prot: assert property (@(posedge mclk) disable iff (reset) // R16
    (launch && state == ST_IDLE && cmdCode == CMD_ERASE_ALL && !pflashProt[PP_OPEN]) |=> !running)
    else $error("erase all ran with protection closed");
  a_run_length: assert property (@(posedge mclk) disable iff (reset) // R23
    (state == ST_IDLE && next_state == ST_RUN) |=> running [*8]) else $error("command ended early");
  c_launch: cover property (@(posedge mclk) disable iff (reset) launch ##1 running);
  c_finish: cover property (@(posedge mclk) disable iff (reset) running ##1 !running);
  c_acc: cover property (@(posedge mclk) disable iff (reset) $rose(access_error_flag));
endmodule : nvc_controller

// ==== tb_top.sv ====
// tb_top: self-checking bench for the nvm controller register side
// assumes: nvc_controller as dut, zero-wait apb slave, 8-bit registers per word
`timescale 1ns/1ps
module tb_top;
  import nvc_pkg::*;
  logic        mclk;
  logic        reset;
  logic        psel;
  logic        penable;
  logic        pwrite;
  logic [11:0] paddr;
  logic [31:0] pwdata;
  logic [31:0] prdata;
  logic        pready;
  logic        pslverr;
  logic        specialMode;
  logic [17:0] globalAddr;
  logic        pflashHit;
  logic        eepromHit;
  logic        resourceHit;
  logic        arrayBusy;
  logic [31:0] rd;
  logic        se;
  int          numErrors;
  int          checks;
  logic [7:0]  evTab [3] = '{8'h01, 8'h02, 8'h04};
  logic [7:0]  fsTab [3] = '{8'h01, 8'h02, 8'h03};
  logic [7:0]  ppTab [5] = '{8'hA0, 8'h84, 8'h24, 8'hA4, 8'hA4};
  logic [7:0]  epTab [5] = '{8'h80, 8'h80, 8'h80, 8'h00, 8'h80};
  logic [17:0] gaTab [8] = '{18'h1_FFFF, 18'h2_0000, 18'h3_FFFF, 18'h0_0400,
                             18'h0_4000, 18'h0_4000, 18'h0_7FFF, 18'h0_8000};
  logic [7:0]  slTab [8] = '{8'h01, 8'h00, 8'h00, 8'h00, 8'h00, 8'h01, 8'h01, 8'h01};
  logic [2:0]  hitTab [8] = '{3'b000, 3'b100, 3'b100, 3'b010, 3'b000, 3'b001, 3'b001, 3'b000};

  nvc_controller dut (
    .mclk(mclk), .reset(reset), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .specialMode(specialMode), .globalAddr(globalAddr), .pflashHit(pflashHit),
    .eepromHit(eepromHit), .resourceHit(resourceHit), .arrayBusy(arrayBusy)
  );

  // 50 MHz clock
  always #10 mclk = ~mclk;

  // verdict and end of run
  task end_sim;
    $display("errors %0d checks %0d", numErrors, checks);
    if (numErrors == 0 && checks > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : end_sim

  // compare seen against expected
  task chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    checks++;
    if (seen !== exp) begin
      numErrors++;
      $display("CHECK FAILED at %0t: %s seen %h expected %h", $time, msg, seen, exp);
    end
  endtask : chk

  // one apb transfer: setup, access until pready, then release
  task apb(input logic w, input logic [7:0] idx, input logic [1:0] off, input logic [7:0] d);
    int n;
    @(posedge mclk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= {2'b00, idx, off};
    pwdata  <= {24'h0, d};
    @(posedge mclk);
    penable <= 1'b1;
    n = 0;
    do begin
      @(posedge mclk);
      n++;
    end while (pready !== 1'b1 && n < 50);
    if (n >= 50) chk(32'h0, 32'h1, "no pready");
    rd = prdata;
    se = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : apb

  task wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, 2'b00, d);
  endtask : wr

  task rdchk(input logic [7:0] idx, input logic [7:0] exp, input string msg);
    apb(1'b0, idx, 2'b00, 8'h00);
    chk(rd, {24'h0, exp}, msg);
  endtask : rdchk

  // load a command code at parameter index 0 and launch it
  task launch(input logic [7:0] code);
    wr(IDX_PARAM_INDEX, 8'h00);
    wr(IDX_PARAM_HI, code);
    wr(IDX_CMD_STATUS, 8'h80);
    apb(1'b0, IDX_CMD_STATUS, 2'b00, 8'h00);
  endtask : launch

  // bounded wait for the running command to finish
  task waitIdle;
    int n;
    n = 0;
    while (arrayBusy !== 1'b0 && n < 200) begin
      @(posedge mclk);
      n++;
    end
    chk(32'(n < 200), 32'h1, "command never finished");
  endtask : waitIdle

  // watchdog against a hang
  initial begin
    repeat (20000) @(posedge mclk);
    numErrors++;
    end_sim();
  end

  // main sequence
  initial begin
    mclk = 1'b0; reset = 1'b1; psel = 1'b0; penable = 1'b0; pwrite = 1'b0;
    paddr = 12'h000; pwdata = 32'h0; specialMode = 1'b0; globalAddr = 18'h0_0000;
    numErrors = 0;
    checks = 0;
    repeat (20) @(posedge mclk);
    reset <= 1'b0;
    // writes land during the init period
    wr(IDX_CONFIG, 8'h10);
    rdchk(IDX_CONFIG, 8'h10, "config write in init");
    repeat (12) @(posedge mclk);
    rdchk(IDX_CMD_STATUS, 8'h80, "idle status");
    // single event ignored while ignore bit set
    wr(IDX_ARRAY_EVENT, 8'h01);
    repeat (2) @(posedge mclk);
    rdchk(IDX_FAULT_STATUS, 8'h00, "ignored single");
    wr(IDX_CONFIG, 8'h00);
    // single, double, collision events; write 0 keeps, write 1 clears per bit
    for (int i = 0; i < 3; i++) begin
      wr(IDX_ARRAY_EVENT, evTab[i]);
      repeat (2) @(posedge mclk);
      rdchk(IDX_FAULT_STATUS, fsTab[i], "fault flags");
      wr(IDX_FAULT_STATUS, 8'h00);
      rdchk(IDX_FAULT_STATUS, fsTab[i], "write zero");
      wr(IDX_FAULT_STATUS, 8'h01);
      rdchk(IDX_FAULT_STATUS, fsTab[i] & 8'h02, "clear single");
      wr(IDX_FAULT_STATUS, 8'h02);
      rdchk(IDX_FAULT_STATUS, 8'h00, "clear double");
    end
    wr(IDX_FAULT_STATUS, 8'h03);
    rdchk(IDX_FAULT_STATUS, 8'h00, "write cannot set");
    // unmapped and misaligned accesses
    wr(8'h20, 8'hFF);
    rdchk(8'h20, 8'h00, "unmapped read");
    apb(1'b1, IDX_CONFIG, 2'b01, 8'h10);
    chk(32'(se), 32'h1, "misaligned error");
    rdchk(IDX_CONFIG, 8'h00, "dropped writes");
    // command run: busy status, config write dropped, array event write still lands, completion
    launch(CMD_USER_MARGIN);
    chk(rd, 32'h08, "running status");
    chk(32'(arrayBusy), 32'h1, "array busy");
    wr(IDX_ARRAY_EVENT, 8'h02);
    wr(IDX_CONFIG, 8'h10);
    waitIdle();
    rdchk(IDX_CMD_STATUS, 8'h83, "done status with fault");
    wr(IDX_FAULT_STATUS, 8'h03);
    rdchk(IDX_CONFIG, 8'h00, "write while busy");
    // erase all refused unless every protection bit is set
    for (int i = 0; i < 5; i++) begin
      wr(IDX_PFLASH_PROT, ppTab[i]);
      wr(IDX_EEPROM_PROT, epTab[i]);
      launch(CMD_ERASE_ALL);
      chk(rd & 32'h18, (i == 4) ? 32'h08 : 32'h10, "erase all gate");
      waitIdle();
      wr(IDX_CMD_STATUS, 8'h30);
    end
    // field margin only in special mode
    launch(CMD_FIELD_MARGIN);
    chk({29'h0, rd[3], |rd[5:4], 1'b0}, 32'h2, "field margin refused");
    wr(IDX_CMD_STATUS, 8'h30);
    @(posedge mclk);
    specialMode <= 1'b1;
    launch(CMD_FIELD_MARGIN);
    chk(rd & 32'h88, 32'h08, "field margin special");
    waitIdle();
    // unsecure with protection open
    launch(CMD_UNSECURE);
    chk(rd & 32'h88, 32'h08, "unsecure runs");
    waitIdle();
    // erase verify launched at wrong parameter index
    launch(CMD_ERASE_VERIFY);
    chk(rd & 32'h28, 32'h20, "verify bad index");
    wr(IDX_CMD_STATUS, 8'h30);
    rdchk(IDX_CMD_STATUS, 8'h80, "error cleared");
    // global address decode with resource select
    for (int i = 0; i < 8; i++) begin
      wr(IDX_RES_SELECT, slTab[i]);
      @(posedge mclk);
      globalAddr <= gaTab[i];
      @(posedge mclk);
      chk(32'({pflashHit, eepromHit, resourceHit}), 32'(hitTab[i]), "decode");
    end
    end_sim();
  end
endmodule : tb_top
